// >>> hdl/wlsr_ctrl.sv
// write-lock, supply-error reporting and soft-reset key control
// Summary of operation
// - die temperature register read-only, reset zero
// - lock set blocks writes except reset key
// - lock bit sticks until device reset
// - locked: recompute and compare integrity code
// - locked: self-test disabled, start refused
// - report-disable bit selects supply error reporting
// - spi, disable 0: silent, then one code
// - spi, disable 0: clear on read, timer zero
// - spi, disable 1: silent while timer runs
// - spi, disable 1: auto clear at zero
// - i2c: silent until expiry, status1 read clears
// - three key writes 00, 11, 10 reset
// - lock register write answer echoes new contents
// - final key write: no answer, no ack
// - reads show key zero, abort sequence
// - key field excluded from integrity code
// - one recovery timer, reloaded during faults
// - code mismatch sets integrity error flag
`timescale 1ns/1ps
module wlsr_ctrl #(
  parameter int unsigned RCV_CYCLES = wlsr_pkg::SUPPLY_RECOVERY_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_data_tx,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic i2c_mode,
  input wire logic supply_fault,
  input wire logic [7:0] temp_value,
  input wire logic [31:0] user_image,
  input wire logic selftest_req,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_error_code,
  output logic i2c_ack,
  output logic soft_reset,
  output logic user_write_enable,
  output logic selftest_enable,
  output logic selftest_start,
  output logic integrity_error,
  output logic supply_error,
  output logic init_done_lock,
  output logic supply_error_report_disable
);
  localparam logic [19:0] RCV_LOAD = RCV_CYCLES[19:0];

  // synchronised supply fault level
  wlsr_sync_if fault_if ();
  assign fault_if.raw = supply_fault;
  wlsr_sync u_fault_sync (
    .mclk (mclk),
    .rst_n (rst_n),
    .port (fault_if)
  );
  logic fault_lvl;
  assign fault_lvl = fault_if.level;

  // state
  logic [7:0] temp_q;
  logic lock_q;
  logic sup_dis_q;
  logic [2:0] rsv_hi_q;
  logic rsv_lo_q;
  logic lock_seen_q;
  wlsr_pkg::wlsr_key_t key_st_q;
  wlsr_pkg::wlsr_key_t key_st_d;
  logic [19:0] timer_q;
  logic sup_err_q;
  logic code_pend_q;
  logic [7:0] code_ref_q;
  logic integ_err_q;
  logic srst_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic rsp_code_q;
  logic ack_q;

  // command decode
  logic reg_rd;
  logic reg_wr;
  logic wr_lock;
  logic key_final;
  logic timer_zero;
  logic answer;
  logic send_code;
  logic rd_status1;
  logic rd_status2;
  logic [7:0] lock_view;
  logic [7:0] code_now;

  assign reg_rd = cmd_valid && !cmd_data_tx && !cmd_write;
  assign reg_wr = cmd_valid && !cmd_data_tx && cmd_write;
  assign wr_lock = reg_wr && (cmd_addr == wlsr_pkg::LOCK_CTRL_ADDR);
  assign timer_zero = (timer_q == wlsr_pkg::TIMER_ZERO);
  assign rd_status1 = reg_rd && (cmd_addr == wlsr_pkg::STATUS1_ADDR);
  assign rd_status2 = reg_rd && (cmd_addr == wlsr_pkg::STATUS2_ADDR);

  // third correct key write completes the sequence
  assign key_final = wr_lock && (key_st_q == wlsr_pkg::WLSR_KEY_GOT2) &&
    (cmd_wdata[wlsr_pkg::RST_MSB:wlsr_pkg::RST_LSB] ==
     wlsr_pkg::KEY_STEP3);

  // no answer at all while recovering; none for the final key write
  assign answer = cmd_valid && timer_zero && !key_final;

  // one error-code answer after recovery, spi with reporting on
  assign send_code = answer && code_pend_q;

  // integrity code over user image plus lock bits, key field left out
  function automatic logic [7:0] wlsr_code(input logic [31:0] img,
                                           input logic [5:0] lk);
    logic [7:0] c;
    logic [37:0] bits;
    c = wlsr_pkg::CODE_RESET;
    bits = {img, lk};
    for (int i = 37; i >= 0; i--) begin
      if (c[7] ^ bits[i]) begin
        c = {c[6:0], 1'b0} ^ wlsr_pkg::CODE_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : wlsr_code

  assign code_now = wlsr_code(user_image,
    {lock_q, rsv_hi_q, sup_dis_q, rsv_lo_q});

  // lock register as read back; key field always reads zero
  assign lock_view = {lock_q, rsv_hi_q, sup_dis_q, rsv_lo_q, 2'b00};

  // die temperature follows the sensor, writes never reach it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= wlsr_pkg::DIE_TEMP_RESET;
    end else if (srst_q) begin
      temp_q <= wlsr_pkg::DIE_TEMP_RESET;
    end else begin
      temp_q <= temp_value;
    end
  end

  // lock control bits; the key field is never stored, it reads zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= wlsr_pkg::LOCK_CTRL_RESET[wlsr_pkg::LOCK_POS];
      sup_dis_q <= wlsr_pkg::LOCK_CTRL_RESET[wlsr_pkg::SUP_DIS_POS];
      rsv_hi_q <= wlsr_pkg::LOCK_CTRL_RESET[6:4];
      rsv_lo_q <= wlsr_pkg::LOCK_CTRL_RESET[2];
    end else if (srst_q) begin
      lock_q <= wlsr_pkg::LOCK_CTRL_RESET[wlsr_pkg::LOCK_POS];
      sup_dis_q <= wlsr_pkg::LOCK_CTRL_RESET[wlsr_pkg::SUP_DIS_POS];
      rsv_hi_q <= wlsr_pkg::LOCK_CTRL_RESET[6:4];
      rsv_lo_q <= wlsr_pkg::LOCK_CTRL_RESET[2];
    end else if (wr_lock && !lock_q) begin
      // a write may set the lock but never clear it
      lock_q <= cmd_wdata[wlsr_pkg::LOCK_POS];
      sup_dis_q <= cmd_wdata[wlsr_pkg::SUP_DIS_POS];
      rsv_hi_q <= cmd_wdata[6:4];
      rsv_lo_q <= cmd_wdata[2];
    end
  end

  // reset key tracker
  always_comb begin
    key_st_d = key_st_q;
    if (wr_lock) begin
      case (key_st_q)
        wlsr_pkg::WLSR_KEY_IDLE: begin
          if (cmd_wdata[1:0] == wlsr_pkg::KEY_STEP1) begin
            key_st_d = wlsr_pkg::WLSR_KEY_GOT1;
          end
        end
        wlsr_pkg::WLSR_KEY_GOT1: begin
          if (cmd_wdata[1:0] == wlsr_pkg::KEY_STEP2) begin
            key_st_d = wlsr_pkg::WLSR_KEY_GOT2;
          end else if (cmd_wdata[1:0] == wlsr_pkg::KEY_STEP1) begin
            key_st_d = wlsr_pkg::WLSR_KEY_GOT1;
          end else begin
            key_st_d = wlsr_pkg::WLSR_KEY_IDLE;
          end
        end
        wlsr_pkg::WLSR_KEY_GOT2: begin
          // a stray 00 counts as a fresh first step
          if (cmd_wdata[1:0] == wlsr_pkg::KEY_STEP1) begin
            key_st_d = wlsr_pkg::WLSR_KEY_GOT1;
          end else begin
            key_st_d = wlsr_pkg::WLSR_KEY_IDLE;
          end
        end
        default: begin
          key_st_d = wlsr_pkg::WLSR_KEY_IDLE;
        end
      endcase
    end else if (reg_wr) begin
      // only consecutive writes to the lock register count
      key_st_d = wlsr_pkg::WLSR_KEY_IDLE;
    end else if (reg_rd) begin
      key_st_d = wlsr_pkg::WLSR_KEY_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_st_q <= wlsr_pkg::WLSR_KEY_IDLE;
    end else if (srst_q) begin
      key_st_q <= wlsr_pkg::WLSR_KEY_IDLE;
    end else begin
      key_st_q <= key_st_d;
    end
  end

  // soft reset pulse; temperature, lock bits, key tracker and integrity flag clear on the next edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= key_final && !srst_q;
    end
  end

  // shared recovery timer, held at full while any fault is seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= wlsr_pkg::TIMER_ZERO;
    end else if (fault_lvl) begin
      timer_q <= RCV_LOAD;
    end else if (!timer_zero) begin
      timer_q <= timer_q - wlsr_pkg::TIMER_ONE;
    end
  end

  // supply error flag; a present fault always wins over a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sup_err_q <= 1'b0;
    end else if (fault_lvl) begin
      sup_err_q <= 1'b1;
    end else if (timer_zero) begin
      if (i2c_mode) begin
        if (rd_status1) begin
          sup_err_q <= 1'b0;
        end
      end else if (sup_dis_q) begin
        sup_err_q <= 1'b0;
      end else if (rd_status1 || send_code) begin
        sup_err_q <= 1'b0;
      end
    end
  end

  // error code owed for exactly one spi answer after recovery
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_pend_q <= 1'b0;
    end else if (fault_lvl && !i2c_mode && !sup_dis_q) begin
      code_pend_q <= 1'b1;
    end else if (send_code || (rd_status1 && timer_zero) || i2c_mode ||
                 sup_dis_q) begin
      code_pend_q <= 1'b0;
    end
  end

  // the lock write itself changes coded bits, so checking waits a cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_seen_q <= 1'b0;
    end else begin
      lock_seen_q <= lock_q;
    end
  end

  // reference tracks through the first locked cycle, then freezes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_ref_q <= wlsr_pkg::CODE_RESET;
    end else if (!lock_q || !lock_seen_q) begin
      code_ref_q <= code_now;
    end
  end

  // mismatch flag; status2 read or error-carrying data clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      integ_err_q <= 1'b0;
    end else if (srst_q) begin
      integ_err_q <= 1'b0;
    end else if (lock_q && lock_seen_q && (code_now != code_ref_q)) begin
      integ_err_q <= 1'b1;
    end else if ((rd_status2 || (cmd_data_tx && cmd_valid)) && answer) begin
      integ_err_q <= 1'b0;
    end
  end

  // answer: echo on lock register write, register view on read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      rsp_code_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      rsp_valid_q <= answer;
      rsp_code_q <= send_code;
      ack_q <= answer && i2c_mode;
      rsp_data_q <= 8'h00;
      if (answer && reg_wr && (cmd_addr == wlsr_pkg::LOCK_CTRL_ADDR)) begin
        // new contents, including the key just written
        if (lock_q) begin
          rsp_data_q <= {lock_view[7:2], cmd_wdata[1:0]};
        end else begin
          rsp_data_q <= {lock_q | cmd_wdata[7], cmd_wdata[6:0]};
        end
      end else if (answer && reg_rd) begin
        case (cmd_addr)
          wlsr_pkg::DIE_TEMP_ADDR: rsp_data_q <= temp_q;
          wlsr_pkg::LOCK_CTRL_ADDR: rsp_data_q <= lock_view;
          default: rsp_data_q <= 8'h00;
        endcase
      end
    end
  end

  // outputs
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_error_code = rsp_code_q;
  assign i2c_ack = ack_q;
  assign soft_reset = srst_q;
  assign user_write_enable = !lock_q;
  assign selftest_enable = !lock_q;
  assign selftest_start = selftest_req && !lock_q;
  assign integrity_error = integ_err_q;
  assign supply_error = sup_err_q;
  assign init_done_lock = lock_q;
  assign supply_error_report_disable = sup_dis_q;
endmodule : wlsr_ctrl

// >>> include/wlsr_pkg.sv
// constants shared by the write-lock and soft-reset control block
package wlsr_pkg;
  // register offsets
  localparam logic [7:0] STATUS1_ADDR = 8'h02;
  localparam logic [7:0] STATUS2_ADDR = 8'h03;
  localparam logic [7:0] DIE_TEMP_ADDR = 8'h0e;
  localparam logic [7:0] LOCK_CTRL_ADDR = 8'h10;
  // lock control field positions
  localparam int LOCK_POS = 7;
  localparam int SUP_DIS_POS = 3;
  localparam int RST_LSB = 0;
  localparam int RST_MSB = 1;
  // reset values
  localparam logic [7:0] DIE_TEMP_RESET = 8'h00;
  localparam logic [7:0] LOCK_CTRL_RESET = 8'h00;
  localparam logic [7:0] CODE_RESET = 8'h00;
  // reset key steps, written as {bit1, bit0}
  localparam logic [1:0] KEY_STEP1 = 2'b00;
  localparam logic [1:0] KEY_STEP2 = 2'b11;
  localparam logic [1:0] KEY_STEP3 = 2'b10;
  // integrity code polynomial, x^8+x^2+x+1
  localparam logic [7:0] CODE_POLY = 8'h07;
  localparam int USER_IMAGE_W = 32;
  // supply recovery interval, plain default
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned SUPPLY_RECOVERY_US = 1000;
  localparam int unsigned SUPPLY_RECOVERY_CYCLES =
    SUPPLY_RECOVERY_US * CLK_MHZ;
  localparam int TIMER_W = 20;
  localparam logic [19:0] TIMER_ZERO = 20'h0_0000;
  localparam logic [19:0] TIMER_ONE = 20'h0_0001;
  // reset key tracker states
  typedef enum logic [1:0] {
    WLSR_KEY_IDLE = 2'b00,
    WLSR_KEY_GOT1 = 2'b01,
    WLSR_KEY_GOT2 = 2'b10
  } wlsr_key_t;
endpackage : wlsr_pkg

// >>> include/wlsr_sync_if.sv
// raw pin level and its filtered copy between top and synchroniser
`timescale 1ns/1ps
interface wlsr_sync_if;
  logic raw;
  logic level;
  modport src (output raw, input level);
  modport sync (input raw, output level);
endinterface : wlsr_sync_if

// >>> hdl/wlsr_sync.sv
// three-flop synchroniser with agreement filter
`timescale 1ns/1ps
module wlsr_sync (
  input wire logic mclk,
  input wire logic rst_n,
  wlsr_sync_if.sync port
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // s1 feeds only s2; level moves once s2 and s3 agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= port.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign port.level = level_q;
endmodule : wlsr_sync

// >>> testbench/wlsr_ctrl_chk.sv
// assertion checker on the write-lock and soft-reset control ports
`timescale 1ns/1ps
module wlsr_ctrl_chk #(
  parameter int unsigned RCV_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_data_tx,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic i2c_mode,
  input wire logic supply_fault,
  input wire logic [7:0] temp_value,
  input wire logic [31:0] user_image,
  input wire logic selftest_req,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_error_code,
  input wire logic i2c_ack,
  input wire logic soft_reset,
  input wire logic user_write_enable,
  input wire logic selftest_enable,
  input wire logic selftest_start,
  input wire logic integrity_error,
  input wire logic supply_error,
  input wire logic init_done_lock,
  input wire logic supply_error_report_disable
);
  logic lk_wr;
  logic lk_rd;
  logic k3;
  // decoded accesses to the lock control register
  assign lk_wr = cmd_valid && cmd_write && !cmd_data_tx &&
    cmd_addr == wlsr_pkg::LOCK_CTRL_ADDR;
  assign lk_rd = cmd_valid && !cmd_write && !cmd_data_tx &&
    cmd_addr == wlsr_pkg::LOCK_CTRL_ADDR;
  assign k3 = lk_wr && cmd_wdata[1:0] == wlsr_pkg::KEY_STEP3;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // one key step, only back-to-back runs are checked for the pulse
  sequence s_key(logic [1:0] v);
    lk_wr && cmd_wdata[1:0] == v;
  endsequence
  property p_key;
    s_key(wlsr_pkg::KEY_STEP1) ##1 s_key(wlsr_pkg::KEY_STEP2) ##1
      s_key(wlsr_pkg::KEY_STEP3) |=> soft_reset && !rsp_valid && !i2c_ack;
  endproperty
  a_key: assert property (p_key) else $error("key reset missing");
  property p_only;
    soft_reset |-> $past(k3);
  endproperty
  a_only: assert property (p_only) else $error("stray reset");
  property p_stick;
    init_done_lock && !soft_reset |=> init_done_lock;
  endproperty
  a_stick: assert property (p_stick) else $error("lock dropped");
  property p_clr;
    soft_reset |=> !init_done_lock;
  endproperty
  a_clr: assert property (p_clr) else $error("lock kept");
  property p_echo;
    lk_wr && !init_done_lock |=> !rsp_valid || rsp_data == $past(cmd_wdata);
  endproperty
  a_echo: assert property (p_echo) else $error("bad echo");
  property p_frz;
    lk_wr && init_done_lock |=> !rsp_valid || rsp_data[7];
  endproperty
  a_frz: assert property (p_frz) else $error("lock bit lost");
  property p_rdk;
    lk_rd |=> !rsp_valid || rsp_data[1:0] == 2'b00;
  endproperty
  a_rdk: assert property (p_rdk) else $error("key read");
  property p_st;
    selftest_start == (selftest_req && !init_done_lock) &&
      selftest_enable == !init_done_lock;
  endproperty
  a_st: assert property (p_st) else $error("self-test gate");
  property p_err;
    rsp_error_code |-> rsp_valid && !i2c_mode && !supply_error_report_disable;
  endproperty
  a_err: assert property (p_err) else $error("bad error code");
endmodule : wlsr_ctrl_chk
bind wlsr_ctrl wlsr_ctrl_chk #(.RCV_CYCLES(RCV_CYCLES)) wlsr_ctrl_chk_inst (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_data_tx(cmd_data_tx), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
  .i2c_mode(i2c_mode), .supply_fault(supply_fault), .temp_value(temp_value),
  .user_image(user_image), .selftest_req(selftest_req), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_error_code(rsp_error_code), .i2c_ack(i2c_ack),
  .soft_reset(soft_reset), .user_write_enable(user_write_enable),
  .selftest_enable(selftest_enable), .selftest_start(selftest_start),
  .integrity_error(integrity_error), .supply_error(supply_error),
  .init_done_lock(init_done_lock),
  .supply_error_report_disable(supply_error_report_disable));

// >>> testbench/wlsr_env.sv
// supply monitor model: fault level changes on its own slow clock
`timescale 1ns/1ps
module wlsr_env (
  input wire logic fault_req,
  output logic supply_fault
);
  logic lclk = 1'b0;
  // 320 ns clock, eight mclk periods, so the fault edge always lands on a falling edge of mclk
  always #160 lclk = ~lclk;
  // unknown only until the first slow edge, well inside reset
  always @(posedge lclk) supply_fault <= fault_req;
endmodule : wlsr_env

// >>> testbench/wlsr_ctrl_tb.sv
// self-checking bench for the write-lock and soft-reset control
`timescale 1ns/1ps
module wlsr_ctrl_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_data_tx = 1'b0;
  logic i2c_mode = 1'b0, selftest_req = 1'b0, fault_req = 1'b0;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, temp_value = 8'h5a;
  logic [31:0] user_image = 32'h1234_5678;
  logic supply_fault, rsp_valid, rsp_error_code, i2c_ack, soft_reset;
  logic user_write_enable, selftest_enable, selftest_start, init_done_lock;
  logic integrity_error, supply_error, supply_error_report_disable;
  logic [7:0] rsp_data, rd;
  logic rv, ec, ak, sr;
  int failures = 0, n_checks = 0, cyc = 0;
  // bench clock, 25 MHz
  always #20 mclk = ~mclk;
  wlsr_ctrl #(.RCV_CYCLES(20)) wlsr_ctrl_inst (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_data_tx(cmd_data_tx), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .i2c_mode(i2c_mode), .supply_fault(supply_fault), .temp_value(temp_value),
    .user_image(user_image), .selftest_req(selftest_req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error_code(rsp_error_code), .i2c_ack(i2c_ack),
    .soft_reset(soft_reset), .user_write_enable(user_write_enable),
    .selftest_enable(selftest_enable), .selftest_start(selftest_start),
    .integrity_error(integrity_error), .supply_error(supply_error),
    .init_done_lock(init_done_lock),
    .supply_error_report_disable(supply_error_report_disable));
  wlsr_env wlsr_env_inst (.fault_req(fault_req), .supply_fault(supply_fault));
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // one command, answer captured in the cycle after it is taken
  task cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
    rv = rsp_valid;
    rd = rsp_data;
    ec = rsp_error_code;
    ak = i2c_ack;
    sr = soft_reset;
  endtask : cmd
  // three back-to-back writes of the key field
  task key3(input logic [5:0] v, input logic exp_sr);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_write <= 1'b1;
      cmd_addr <= wlsr_pkg::LOCK_CTRL_ADDR;
      cmd_wdata <= {6'h00, v[5-2*i -: 2]};
    end
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
    chk("reset pulse", {7'h00, exp_sr}, {7'h00, soft_reset});
    chk("last answer", {7'h00, !exp_sr}, {7'h00, rsp_valid});
  endtask : key3
  // fault long enough to be seen, returns while the timer still runs
  task fault;
    @(posedge mclk);
    fault_req <= 1'b1;
    repeat (30) @(posedge mclk);
    fault_req <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask : fault
  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    selftest_req <= 1'b1;
    cmd(1'b0, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    chk("lock reset", 8'h00, rd);
    cmd(1'b1, wlsr_pkg::DIE_TEMP_ADDR, 8'hff);
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("temperature", 8'h5a, rd);
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h0b);
    chk("echo", 8'h0b, rd);
    chk("rep disable", 8'h01, {7'h00, supply_error_report_disable});
    cmd(1'b0, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    chk("key read", 8'h08, rd);
    // a read in mid sequence, then a wrong third value, then the key
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h03);
    cmd(1'b0, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h02);
    chk("aborted", 8'h00, {7'h00, sr});
    key3(6'b00_11_11, 1'b0);
    key3(6'b00_11_10, 1'b1);
    cmd(1'b0, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    chk("after reset", 8'h00, rd);
    // locking freezes all but the key field
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h80);
    chk("lock bit", 8'h01, {7'h00, init_done_lock});
    chk("write enable", 8'h00, {7'h00, user_write_enable});
    chk("self-test", 8'h00, {7'h00, selftest_start});
    chk("self-test en", 8'h00, {7'h00, selftest_enable});
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h09);
    chk("locked echo", 8'h81, rd);
    cmd(1'b0, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    chk("locked read", 8'h80, rd);
    chk("code clean", 8'h00, {7'h00, integrity_error});
    @(posedge mclk);
    user_image <= 32'h1234_5679;
    repeat (10) @(posedge mclk);
    #1;
    chk("code error", 8'h01, {7'h00, integrity_error});
    key3(6'b00_11_10, 1'b1);
    cmd(1'b0, wlsr_pkg::LOCK_CTRL_ADDR, 8'h00);
    chk("unlocked", 8'h00, rd);
    chk("self-test back", 8'h01, {7'h00, selftest_start});
    // spi, report disable 0: silent, then one error code
    fault;
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("silent", 8'h00, {7'h00, rv});
    repeat (40) @(posedge mclk);
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("error code", 8'h01, {7'h00, ec});
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("code once", 8'h00, {7'h00, ec});
    chk("cleared", 8'h00, {7'h00, supply_error});
    // spi, report disable 1: silent, clears by itself
    cmd(1'b1, wlsr_pkg::LOCK_CTRL_ADDR, 8'h08);
    fault;
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("silent dis", 8'h00, {7'h00, rv});
    repeat (40) @(posedge mclk);
    #1;
    chk("self clear", 8'h00, {7'h00, supply_error});
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("resumed", 8'h01, {7'h00, rv});
    // i2c: silent while recovering, held until a status read
    @(posedge mclk);
    i2c_mode <= 1'b1;
    fault;
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("i2c silent", 8'h00, {7'h00, ak});
    repeat (40) @(posedge mclk);
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("i2c held", 8'h01, {7'h00, supply_error});
    cmd(1'b0, wlsr_pkg::STATUS1_ADDR, 8'h00);
    chk("i2c ack", 8'h01, {7'h00, ak});
    cmd(1'b0, wlsr_pkg::DIE_TEMP_ADDR, 8'h00);
    chk("i2c clear", 8'h00, {7'h00, supply_error});
    // final key write in i2c: no answer and no acknowledge
    key3(6'b00_11_10, 1'b1);
    chk("final ack", 8'h00, {7'h00, i2c_ack});
    stop_test;
  end
endmodule : wlsr_ctrl_tb
